// ==== core/pfa_pkg.sv ====
// shared constants for the function A status record packer
package pfa_pkg;
	// ----------------------------------------
	// record layout and telegram placement
	// ----------------------------------------
	localparam int REC_BYTES = 8;
	localparam logic [7:0] TELE_FIRST = 8'h0e;
	localparam logic [7:0] TELE_LAST = 8'h15;
	localparam logic [63:0] REC_RST = 64'h0;
	localparam int REC_WARN_FREE = 0;
	localparam int REC_GUARD_FREE = 1;
	localparam int REC_ACTIVE = 4;
	localparam int REC_WARN_RST = 8;
	localparam int REC_GUARD_RST = 9;
	localparam int REC_WARN_SEG = 16;
	localparam int REC_GUARD_SEG = 24;
	localparam int REC_PAIR1 = 32;
	localparam int REC_PAIR2 = 36;
	localparam int REC_PAIR3 = 40;
	localparam int REC_PRESET1 = 48;
	localparam int REC_PRESET2 = 49;
	localparam logic [3:0] PAIR_MIN = 4'h1;
	localparam logic [3:0] PAIR_MAX = 4'ha;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REC_LO = 8'h04;
	localparam logic [7:0] ADDR_REC_HI = 8'h08;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;
	localparam logic [7:0] ADDR_ID = 8'h14;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_PAIR3 = 1;
	localparam logic [1:0] CTRL_RST = 2'h1;
	localparam int EVT_N = 5;
	localparam int EVT_GUARD_OCC = 0;
	localparam int EVT_WARN_OCC = 1;
	localparam int EVT_RESTART = 2;
	localparam int EVT_PAIR_RANGE = 3;
	localparam int EVT_PRESET_CHG = 4;
	localparam logic [4:0] MASK_RST = 5'h0;
endpackage

// ==== core/pfa_rec_if.sv ====
// carrier between the register shell and the record packer
`timescale 1ns/1ps
interface pfa_rec_if;
	logic load;
	logic pair3_en;
	logic warn_free;
	logic guard_free;
	logic active;
	logic warn_rst;
	logic guard_rst;
	logic [1:0] warn_seg;
	logic [1:0] guard_seg;
	logic [3:0] pair1;
	logic [3:0] pair2;
	logic [3:0] pair3;
	logic preset1;
	logic preset2;
	logic [63:0] record;

	modport packer (
		input load, pair3_en, warn_free, guard_free, active, warn_rst, guard_rst,
		input warn_seg, guard_seg, pair1, pair2, pair3, preset1, preset2,
		output record
	);
	modport owner (
		output load, pair3_en, warn_free, guard_free, active, warn_rst, guard_rst,
		output warn_seg, guard_seg, pair1, pair2, pair3, preset1, preset2,
		input record
	);
endinterface

// ==== core/pfa_rec_pack.sv ====
// assembles the eight-byte function A status record
`timescale 1ns/1ps
module pfa_rec_pack (
	input wire logic core_clk_i,
	input wire logic srst_i,
	pfa_rec_if.packer rec
);
	logic [63:0] record_ff;
	logic [63:0] nxt_record;

	// ----------------------------------------
	// record assembly
	// ----------------------------------------
	always_comb begin
		nxt_record = 64'h0;
		nxt_record[pfa_pkg::REC_WARN_FREE] = rec.warn_free;
		nxt_record[pfa_pkg::REC_GUARD_FREE] = rec.guard_free;
		nxt_record[pfa_pkg::REC_ACTIVE] = rec.active;
		nxt_record[pfa_pkg::REC_WARN_RST] = rec.warn_rst;
		nxt_record[pfa_pkg::REC_GUARD_RST] = rec.guard_rst;
		nxt_record[pfa_pkg::REC_WARN_SEG +: 2] = rec.warn_seg;
		nxt_record[pfa_pkg::REC_GUARD_SEG +: 2] = rec.guard_seg;
		// pair numbers, third only when enabled
		nxt_record[pfa_pkg::REC_PAIR1 +: 4] = rec.pair1;
		nxt_record[pfa_pkg::REC_PAIR2 +: 4] = rec.pair2;
		nxt_record[pfa_pkg::REC_PAIR3 +: 4] = rec.pair3_en ? rec.pair3 : 4'h0;
		nxt_record[pfa_pkg::REC_PRESET1] = rec.preset1;
		nxt_record[pfa_pkg::REC_PRESET2] = rec.preset2;
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			record_ff <= pfa_pkg::REC_RST;
		end else if (rec.load) begin
			record_ff <= nxt_record;
		end
	end

	assign rec.record = record_ff;
endmodule

// ==== core/pfa_status_packer.sv ====
// function A status record packer with telegram port and APB registers
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// Notes on behaviour
// - record fills telegram bytes 14 to 21
// - byte 0 bits 0/1: zones, 1 free
// - byte 0 bit 4: function active
// - byte 1 bits 0/1: restart pending
// - bytes 2/3: segment free bits
// - pair numbers 1-10, four bits each; the range event checks the lower limit on pair 1 only
// - byte 6 bits 0/1: preset pair selected
module pfa_status_packer #(
	// arbitrary identification value
	parameter logic [31:0] ID_VALUE = 32'h00c0ffee
) (
	input wire logic core_clk_i,
	input wire logic srst_i,
	input wire logic warn_zone_a_free_i,
	input wire logic guard_zone_a_free_i,
	input wire logic func_a_active_i,
	input wire logic warn_zone_a_restart_pending_i,
	input wire logic guard_zone_a_restart_pending_i,
	input wire logic warn_zone_a_seg1_free_i,
	input wire logic warn_zone_a_seg2_free_i,
	input wire logic guard_zone_a_seg1_free_i,
	input wire logic guard_zone_a_seg2_free_i,
	input wire logic [3:0] pair_sel1_i,
	input wire logic [3:0] pair_sel2_i,
	input wire logic [3:0] pair_sel3_i,
	input wire logic preset_pair1_selected_i,
	input wire logic preset_pair2_selected_i,
	input wire logic tele_rd_i,
	input wire logic [7:0] tele_idx_i,
	output logic [7:0] tele_byte_o,
	output logic tele_hit_o,
	output logic tele_vld_o,
	output logic [63:0] rec_o,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq_o
);
	pfa_rec_if rec_if ();

	logic [1:0] ctrl_ff;
	logic [pfa_pkg::EVT_N-1:0] stat_ff;
	logic [pfa_pkg::EVT_N-1:0] mask_ff;
	logic [pfa_pkg::EVT_N-1:0] evt;
	logic [pfa_pkg::EVT_N-1:0] w1c;
	logic [63:0] prev_ff;
	logic prev_vld_ff;
	logic ack_ff;
	logic [31:0] prdata_ff;
	logic [31:0] rd_val;
	logic rd_err;
	logic acc_first;
	logic acc_done;
	logic [7:0] tele_byte_ff;
	logic tele_hit_ff;
	logic tele_vld_ff;
	logic [2:0] tele_sel;
	logic tele_in;
	logic pair_bad;

	// ----------------------------------------
	// record packer
	// ----------------------------------------
	assign rec_if.load = ctrl_ff[pfa_pkg::CTRL_RUN];
	assign rec_if.pair3_en = ctrl_ff[pfa_pkg::CTRL_PAIR3];
	assign rec_if.warn_free = warn_zone_a_free_i;
	assign rec_if.guard_free = guard_zone_a_free_i;
	assign rec_if.active = func_a_active_i;
	assign rec_if.warn_rst = warn_zone_a_restart_pending_i;
	assign rec_if.guard_rst = guard_zone_a_restart_pending_i;
	assign rec_if.warn_seg = {warn_zone_a_seg2_free_i, warn_zone_a_seg1_free_i};
	assign rec_if.guard_seg = {guard_zone_a_seg2_free_i, guard_zone_a_seg1_free_i};
	assign rec_if.pair1 = pair_sel1_i;
	assign rec_if.pair2 = pair_sel2_i;
	assign rec_if.pair3 = pair_sel3_i;
	assign rec_if.preset1 = preset_pair1_selected_i;
	assign rec_if.preset2 = preset_pair2_selected_i;

	pfa_rec_pack u_pfa_rec_pack (
		.core_clk_i(core_clk_i),
		.srst_i(srst_i),
		.rec(rec_if.packer)
	);

	assign rec_o = rec_if.record;

	// ----------------------------------------
	// telegram byte port
	// ----------------------------------------
	// window 14..21 maps to record bytes 0..7
	assign tele_in = (tele_idx_i >= pfa_pkg::TELE_FIRST) && (tele_idx_i <= pfa_pkg::TELE_LAST);
	assign tele_sel = 3'(tele_idx_i - pfa_pkg::TELE_FIRST);

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			tele_byte_ff <= 8'h00;
			tele_hit_ff <= 1'b0;
			tele_vld_ff <= 1'b0;
		end else begin
			tele_vld_ff <= tele_rd_i;
			if (tele_rd_i) begin
				tele_hit_ff <= tele_in;
				tele_byte_ff <= tele_in ? rec_if.record[tele_sel*8 +: 8] : 8'h00;
			end
		end
	end

	assign tele_byte_o = tele_byte_ff;
	assign tele_hit_o = tele_hit_ff;
	assign tele_vld_o = tele_vld_ff;

	// ----------------------------------------
	// events from record changes, plus pair number range check on the current record
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			prev_ff <= pfa_pkg::REC_RST;
			prev_vld_ff <= 1'b0;
		end else begin
			prev_ff <= rec_if.record;
			prev_vld_ff <= 1'b1;
		end
	end

	always_comb begin
		pair_bad = 1'b0;
		if (rec_if.record[pfa_pkg::REC_ACTIVE]) begin
			if (rec_if.record[pfa_pkg::REC_PAIR1 +: 4] < pfa_pkg::PAIR_MIN) begin
				pair_bad = 1'b1;
			end
			if (rec_if.record[pfa_pkg::REC_PAIR1 +: 4] > pfa_pkg::PAIR_MAX) begin
				pair_bad = 1'b1;
			end
			if (rec_if.record[pfa_pkg::REC_PAIR2 +: 4] > pfa_pkg::PAIR_MAX) begin
				pair_bad = 1'b1;
			end
			if (rec_if.record[pfa_pkg::REC_PAIR3 +: 4] > pfa_pkg::PAIR_MAX) begin
				pair_bad = 1'b1;
			end
		end
	end

	always_comb begin
		evt = '0;
		if (prev_vld_ff) begin
			evt[pfa_pkg::EVT_GUARD_OCC] = prev_ff[pfa_pkg::REC_GUARD_FREE] &
				~rec_if.record[pfa_pkg::REC_GUARD_FREE];
			evt[pfa_pkg::EVT_WARN_OCC] = prev_ff[pfa_pkg::REC_WARN_FREE] &
				~rec_if.record[pfa_pkg::REC_WARN_FREE];
			evt[pfa_pkg::EVT_RESTART] = (|(rec_if.record[pfa_pkg::REC_WARN_RST +: 2] &
				~prev_ff[pfa_pkg::REC_WARN_RST +: 2]));
			evt[pfa_pkg::EVT_PAIR_RANGE] = pair_bad;
			evt[pfa_pkg::EVT_PRESET_CHG] = (rec_if.record[pfa_pkg::REC_PRESET1 +: 2] !=
				prev_ff[pfa_pkg::REC_PRESET1 +: 2]);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign acc_first = psel && penable && !ack_ff;
	assign acc_done = psel && penable && ack_ff;

	always_comb begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		if (paddr == pfa_pkg::ADDR_CTRL) begin
			rd_val = {30'h0, ctrl_ff};
		end else if (paddr == pfa_pkg::ADDR_REC_LO) begin
			rd_val = rec_if.record[31:0];
		end else if (paddr == pfa_pkg::ADDR_REC_HI) begin
			rd_val = rec_if.record[63:32];
		end else if (paddr == pfa_pkg::ADDR_IRQ_STAT) begin
			rd_val = {27'h0, stat_ff};
		end else if (paddr == pfa_pkg::ADDR_IRQ_MASK) begin
			rd_val = {27'h0, mask_ff};
		end else if (paddr == pfa_pkg::ADDR_ID) begin
			// arbitrary identification value
			rd_val = ID_VALUE;
		end else begin
			rd_err = 1'b1;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ack_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			ack_ff <= acc_first;
			if (acc_first && !pwrite) begin
				prdata_ff <= rd_val;
			end
		end
	end

	assign pready = ack_ff;
	assign pslverr = ack_ff && rd_err;
	assign prdata = prdata_ff;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			ctrl_ff <= pfa_pkg::CTRL_RST;
		end else if (acc_done && pwrite && paddr == pfa_pkg::ADDR_CTRL) begin
			ctrl_ff <= pwdata[1:0];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			mask_ff <= pfa_pkg::MASK_RST;
		end else if (acc_done && pwrite && paddr == pfa_pkg::ADDR_IRQ_MASK) begin
			mask_ff <= pwdata[pfa_pkg::EVT_N-1:0];
		end
	end

	// ----------------------------------------
	// interrupt status, set wins over clear
	// ----------------------------------------
	assign w1c = (acc_done && pwrite && paddr == pfa_pkg::ADDR_IRQ_STAT) ?
		pwdata[pfa_pkg::EVT_N-1:0] : '0;

	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~w1c) | evt;
		end
	end

	assign irq_o = |(stat_ff & mask_ff);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);

	chk_tele_window_map: assert property (
		tele_rd_i && tele_in |=> tele_hit_o && tele_vld_o &&
			tele_byte_o == $past(rec_o[tele_sel*8 +: 8]))
		else $error("telegram byte does not match record byte");

	chk_tele_outside_zero: assert property (
		tele_rd_i && !tele_in |=> !tele_hit_o && tele_byte_o == 8'h00)
		else $error("byte outside window not zero");

	chk_zone_free_bits: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[pfa_pkg::REC_WARN_FREE] == $past(warn_zone_a_free_i) &&
			rec_o[pfa_pkg::REC_GUARD_FREE] == $past(guard_zone_a_free_i))
		else $error("zone free bits wrong");

	chk_active_bit: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[pfa_pkg::REC_ACTIVE] == $past(func_a_active_i))
		else $error("active bit wrong");

	chk_restart_bits: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[9:8] ==
			$past({guard_zone_a_restart_pending_i, warn_zone_a_restart_pending_i}))
		else $error("restart pending bits wrong");

	chk_segment_bits: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[17:16] == $past({warn_zone_a_seg2_free_i,
			warn_zone_a_seg1_free_i}) && rec_o[25:24] == $past({guard_zone_a_seg2_free_i,
			guard_zone_a_seg1_free_i}))
		else $error("segment bits wrong");

	chk_pair_numbers: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[39:32] == $past({pair_sel2_i, pair_sel1_i}) &&
			rec_o[43:40] == ($past(ctrl_ff[pfa_pkg::CTRL_PAIR3]) ? $past(pair_sel3_i) : 4'h0))
		else $error("pair number fields wrong");

	chk_preset_bits: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] |=> rec_o[49:48] ==
			$past({preset_pair2_selected_i, preset_pair1_selected_i}))
		else $error("preset pair bits wrong");

	chk_reserved_zero: assert property (
		rec_o[63:56] == 8'h00 && rec_o[55:50] == 6'h00 && rec_o[47:44] == 4'h0 &&
			rec_o[31:26] == 6'h00 && rec_o[23:18] == 6'h00 && rec_o[15:10] == 6'h00 &&
			rec_o[7:5] == 3'h0 && rec_o[3:2] == 2'h0)
		else $error("reserved record bit set");

	chk_freeze_hold: assert property (
		!ctrl_ff[pfa_pkg::CTRL_RUN] |=> $stable(rec_o))
		else $error("record changed while frozen");

	chk_guard_event: assert property (
		prev_vld_ff && $fell(rec_o[pfa_pkg::REC_GUARD_FREE]) |=> stat_ff[pfa_pkg::EVT_GUARD_OCC])
		else $error("guard occupancy event lost");

	chk_apb_answer: assert property (
		psel && penable && !pready |=> pready)
		else $error("apb answer not after one wait cycle");

	chk_tele_vld_pulse: assert property (
		!$past(srst_i) |-> tele_vld_o == $past(tele_rd_i))
		else $error("telegram valid not one cycle after request");

	chk_tele_hold: assert property (
		!tele_rd_i |=> $stable(tele_byte_o) && $stable(tele_hit_o))
		else $error("telegram byte changed without request");

	chk_stat_sticky: assert property (
		1'b1 |=> (stat_ff & $past(stat_ff & ~w1c)) == $past(stat_ff & ~w1c))
		else $error("status bit lost without a clear");

	chk_set_wins: assert property (
		|evt |=> (stat_ff & $past(evt)) == $past(evt))
		else $error("event did not set status");

	chk_w1c_clear: assert property (
		|(w1c & ~evt) |=> (stat_ff & $past(w1c & ~evt)) == '0)
		else $error("write one did not clear status");

	chk_apb_err: assert property (
		pready |-> pslverr == (paddr > pfa_pkg::ADDR_ID || paddr[1:0] != 2'h0))
		else $error("error response does not match address map");

	chk_pair_range_flag: assert property (
		prev_vld_ff && rec_o[pfa_pkg::REC_ACTIVE] && (rec_o[pfa_pkg::REC_PAIR1 +: 4] < pfa_pkg::PAIR_MIN ||
			rec_o[pfa_pkg::REC_PAIR1 +: 4] > pfa_pkg::PAIR_MAX) |=> stat_ff[pfa_pkg::EVT_PAIR_RANGE])
		else $error("pair number out of range not flagged");

	chk_ctrl_write: assert property (
		psel && penable && pready && pwrite && paddr == pfa_pkg::ADDR_CTRL |=> ctrl_ff == $past(pwdata[1:0]))
		else $error("control write not applied");

	chk_ack_single: assert property (
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	chk_pair3_off: assert property (
		ctrl_ff[pfa_pkg::CTRL_RUN] && !ctrl_ff[pfa_pkg::CTRL_PAIR3] |=> rec_o[pfa_pkg::REC_PAIR3 +: 4] == 4'h0)
		else $error("third pair field not zero while disabled");

	cov_tele_read: cover property (tele_rd_i && tele_in ##1 tele_vld_o);
	cov_guard_occ_irq: cover property ($fell(rec_o[pfa_pkg::REC_GUARD_FREE]) ##[1:3] irq_o);
	cov_pair_range: cover property (stat_ff[pfa_pkg::EVT_PAIR_RANGE]);
	cov_apb_err: cover property (pready && pslverr);
	cov_pair3_field: cover property (ctrl_ff[pfa_pkg::CTRL_PAIR3] && rec_o[pfa_pkg::REC_PAIR3 +: 4] != 4'h0);
endmodule

// ==== tb/pfa_ioc_model.sv ====
// fieldbus controller model that reads telegram bytes
`timescale 1ns/1ps
module pfa_ioc_model (
	input wire logic core_clk_i,
	output logic tele_rd_o,
	output logic [7:0] tele_idx_o
);
	initial begin
		tele_rd_o = 1'b0;
		tele_idx_o = 8'h00;
	end

	// ----------------------------------------
	// read a span of bytes, gap idle cycles apart
	// ----------------------------------------
	task automatic sweep(input logic [7:0] first, input logic [7:0] last, input int gap);
		logic [7:0] i;
		i = first;
		repeat (int'(last - first) + 1) begin
			@(posedge core_clk_i);
			tele_rd_o <= 1'b1;
			tele_idx_o <= i;
			i = i + 8'h01;
			repeat (gap) begin
				@(posedge core_clk_i);
				tele_rd_o <= 1'b0;
				tele_idx_o <= ~tele_idx_o;
			end
		end
		@(posedge core_clk_i);
		tele_rd_o <= 1'b0;
		// idle index is left at the inverse of the next index so a stale value never matches
		tele_idx_o <= ~i;
	endtask
endmodule

// ==== tb/pfa_status_packer_test.sv ====
// self-checking bench for the function A status packer
`timescale 1ns/1ps
module pfa_status_packer_test;
	logic core_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [22:0] in_v = 23'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq_o;
	logic [7:0] tele_byte_o;
	logic tele_hit_o;
	logic tele_vld_o;
	logic [63:0] rec_o;
	logic tele_rd;
	logic [7:0] tele_idx;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	integer seed = 32'he55e;
	logic p3en = 1'b0;
	logic [33:0] apb_q[$];
	logic [8:0] tele_q[$];
	logic [33:0] ae;
	logic [8:0] te;
	logic [22:0] flip[5] = '{23'h2, 23'h1, 23'h8, 23'h200, 23'h200000};

	// ----------------------------------------
	// design, far side and clock
	// ----------------------------------------
	always #5 core_clk_i = ~core_clk_i;
	// arbitrary identity value
	pfa_status_packer #(.ID_VALUE(32'h0000a5a5)) u_pfa_status_packer (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.warn_zone_a_free_i(in_v[0]), .guard_zone_a_free_i(in_v[1]), .func_a_active_i(in_v[2]),
		.warn_zone_a_restart_pending_i(in_v[3]), .guard_zone_a_restart_pending_i(in_v[4]),
		.warn_zone_a_seg1_free_i(in_v[5]), .warn_zone_a_seg2_free_i(in_v[6]),
		.guard_zone_a_seg1_free_i(in_v[7]), .guard_zone_a_seg2_free_i(in_v[8]),
		.pair_sel1_i(in_v[12:9]), .pair_sel2_i(in_v[16:13]), .pair_sel3_i(in_v[20:17]),
		.preset_pair1_selected_i(in_v[21]), .preset_pair2_selected_i(in_v[22]),
		.tele_rd_i(tele_rd), .tele_idx_i(tele_idx), .tele_byte_o(tele_byte_o), .tele_hit_o(tele_hit_o),
		.tele_vld_o(tele_vld_o), .rec_o(rec_o), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
	pfa_ioc_model u_pfa_ioc_model (.core_clk_i(core_clk_i), .tele_rd_o(tele_rd), .tele_idx_o(tele_idx));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	function automatic logic [63:0] exp_rec(input logic [22:0] v);
		logic [63:0] e;
		e = 64'h0;
		e[1:0] = v[1:0];
		e[4] = v[2];
		e[9:8] = v[4:3];
		e[17:16] = v[6:5];
		e[25:24] = v[8:7];
		e[39:32] = v[16:9];
		e[43:40] = p3en ? v[20:17] : 4'h0;
		e[49:48] = v[22:21];
		return e;
	endfunction

	function automatic logic [3:0] pr(input logic [3:0] x);
		return 4'(x % 4'ha) + 4'h1;
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		apb_q.push_back({~w, err, w ? 32'h0 : d});
		@(posedge core_clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : $random(seed);
		@(posedge core_clk_i);
		penable <= 1'b1;
		@(posedge core_clk_i);
		while (pready !== 1'b1)
			@(posedge core_clk_i);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ----------------------------------------
	// result watcher and timeout
	// ----------------------------------------
	always @(posedge core_clk_i) begin
		cyc = cyc + 1;
		if (psel && penable && pready === 1'b1) begin
			ae = apb_q.pop_front();
			check(64'({ae[33], pslverr, ae[33] ? prdata : 32'h0}), 64'(ae));
		end
		if (tele_vld_o === 1'b1) begin
			te = tele_q.pop_front();
			check(64'({tele_hit_o, tele_byte_o}), 64'(te));
		end
		if (cyc == 20000) begin
			mismatches++;
			finish_test();
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		logic [22:0] v;
		logic [63:0] e;
		repeat (3) @(posedge core_clk_i);
		srst_i <= 1'b0;
		@(posedge core_clk_i);
		check(rec_o, 64'h0);
		apb(1'b0, pfa_pkg::ADDR_CTRL, 32'h1, 1'b0);
		apb(1'b0, pfa_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0);
		apb(1'b0, pfa_pkg::ADDR_ID, 32'h0000a5a5, 1'b0);
		apb(1'b0, 8'h18, 32'h0, 1'b1);
		apb(1'b1, 8'h1c, 32'hffffffff, 1'b1);
		for (int i = 0; i < 24; i++) begin
			if (i == 12) begin
				apb(1'b1, pfa_pkg::ADDR_CTRL, 32'h3, 1'b0);
				p3en = 1'b1;
			end
			r = $random(seed);
			v = r[22:0];
			v[20:9] = {pr(r[12:9] ^ r[31:28]), pr(r[30:27]), pr(r[26:23])};
			if (i < 2)
				v[20:9] = i ? 12'ha1a : 12'h1a1;
			@(posedge core_clk_i);
			in_v <= v;
			repeat (2) @(posedge core_clk_i);
			check(rec_o, exp_rec(v));
		end
		e = exp_rec(in_v);
		for (int k = 12; k < 24; k++)
			tele_q.push_back((k >= 14 && k <= 21) ? {1'b1, e[8 * (k - 14) +: 8]} : 9'h0);
		u_pfa_ioc_model.sweep(8'h0c, 8'h17, 0);
		for (int k = 20; k < 23; k++)
			tele_q.push_back((k <= 21) ? {1'b1, e[8 * (k - 14) +: 8]} : 9'h0);
		u_pfa_ioc_model.sweep(8'h14, 8'h16, 2);
		apb(1'b0, pfa_pkg::ADDR_REC_LO, e[31:0], 1'b0);
		apb(1'b0, pfa_pkg::ADDR_REC_HI, e[63:32], 1'b0);
		apb(1'b1, pfa_pkg::ADDR_CTRL, 32'h2, 1'b0);
		in_v <= ~in_v;
		repeat (3) @(posedge core_clk_i);
		check(rec_o, e);
		apb(1'b1, pfa_pkg::ADDR_CTRL, 32'h3, 1'b0);
		apb(1'b1, pfa_pkg::ADDR_IRQ_MASK, 32'h1f, 1'b0);
		for (int k = 0; k < 5; k++) begin
			@(posedge core_clk_i);
			in_v <= 23'h0643e7;
			repeat (4) @(posedge core_clk_i);
			apb(1'b1, pfa_pkg::ADDR_IRQ_STAT, 32'h1f, 1'b0);
			@(posedge core_clk_i);
			check(64'(irq_o), 64'h0);
			in_v <= 23'h0643e7 ^ flip[k];
			repeat (4) @(posedge core_clk_i);
			check(64'(irq_o), 64'h1);
			apb(1'b0, pfa_pkg::ADDR_IRQ_STAT, 32'h1 << k, 1'b0);
		end
		apb(1'b1, pfa_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0);
		@(posedge core_clk_i);
		check(64'(irq_o), 64'h0);
		apb(1'b1, pfa_pkg::ADDR_IRQ_STAT, 32'h1f, 1'b0);
		apb(1'b0, pfa_pkg::ADDR_IRQ_STAT, 32'h0, 1'b0);
		repeat (4) @(posedge core_clk_i);
		check(64'(tele_q.size()), 64'h0);
		check(64'(apb_q.size()), 64'h0);
		finish_test();
	end
endmodule
